//--- core/uplink_trigger_sync_pkg.sv
/*
 * Package for the uplink trigger and sync block: modes, output signal
 * selections, carrier structs and timing constants.
 * Assumes a 250 MHz core clock and a chip rate of 3.84 Mcps.
 */
package uplink_trigger_sync_pkg;

    localparam int unsigned CORE_CLK_MHZ = 250;
    // Chip period in ps at 3.84 Mcps, used to turn chips into core cycles
    localparam int unsigned CHIP_PERIOD_PS = 260417;
    localparam int unsigned CORE_PERIOD_PS = 4000;
    localparam int unsigned BASE_DELAY_CHIPS = 1024;
    localparam int unsigned SFN_EXTRA_MS = 10;
    localparam int unsigned CHIPS_PER_MS = 3840;
    localparam int unsigned SFN_EXTRA_CHIPS = SFN_EXTRA_MS * CHIPS_PER_MS;
    // Internal chip rate divider: 250 MHz / 3.84 MHz rounds down to 65
    localparam int unsigned INT_CHIP_DIV = (CHIP_PERIOD_PS / CORE_PERIOD_PS);
    localparam logic [7:0] INT_CHIP_DIV_W = 8'h41;
    localparam logic [7:0] PROC_LATENCY_CHIPS = 8'h10;
    localparam logic [31:0] FRAME_CLK_10MS = 32'h0000_0001;
    localparam int unsigned CNT_W = 24;
    localparam logic [23:0] DELAY_BASE = 24'h000400;
    localparam logic [23:0] DELAY_SFN = 24'h009600;
    localparam logic [11:0] CFN_RESET = 12'h000;
    localparam int unsigned FIFO_W = 8;
    localparam int unsigned FIFO_D = 16;

    typedef enum logic {MODE_DPCH, MODE_PRACH} mode_t;

    typedef enum logic [3:0] {
        SEL_NONE, SEL_DPDCH_DATA, SEL_DPDCH_CLK, SEL_DPCCH_DATA, SEL_CHIP_CLK,
        SEL_SYNC_REPLY, SEL_MSG_DATA, SEL_MSG_CLK, SEL_PREAMBLE, SEL_FRAME_SYNC
    } out_sel_t;

    typedef enum logic [1:0] {MULT_X1, MULT_X2, MULT_X4} clk_mult_t;

    // Seven output selections: event1..4, data, data clock, sync
    typedef struct packed {
        out_sel_t [6:0] sel;
    } out_map_t;

    typedef struct packed {
        mode_t mode;
        logic sfn_source;
        logic cm_enable;
        logic tpc_enable;
        logic prach_selected;
        logic msg_aich;
        logic ext_clk_source;
        clk_mult_t ext_mult;
        logic [11:0] timing_offset;
        logic [11:0] slot_offset;
        logic [11:0] stop_frame_number_field;
    } cfg_t;

    typedef struct packed {
        logic sync_pulse;
        logic cm_start;
        logic cm_stop;
        logic tpc_step;
        logic tpc_bits;
        logic prach_start;
        logic msg_start;
    } evt_t;

    function automatic out_map_t default_map(input mode_t m);
        out_map_t r;
        r.sel = {7{SEL_NONE}};
        if (m == MODE_DPCH)
        begin
            r.sel[0] = SEL_DPDCH_DATA;
            r.sel[1] = SEL_DPDCH_CLK;
            r.sel[4] = SEL_DPCCH_DATA;
            r.sel[5] = SEL_CHIP_CLK;
            r.sel[6] = SEL_SYNC_REPLY;
        end
        return r;
    endfunction

endpackage

//--- core/sample_fifo.sv
/*
 * Flip-flop FIFO with valid/ready on both sides.
 * Assumes both sides share core_clk.
 */
`timescale 1ns/10ps
module sample_fifo #(
    parameter int W = 8,
    parameter int D = 16
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic nrst,
    // Fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [W-1:0] in_data,
    // Drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data
);
    localparam int AW = $clog2(D);
    logic [W-1:0] mem [D];
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0] count;
    logic push;
    logic pop;

    assign in_ready = (count != D[AW:0]);
    assign out_valid = (count != '0);
    assign out_data = mem[rd_ptr];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always_ff @(posedge core_clk)
    begin
        if (push)
            mem[wr_ptr] <= in_data;
    end

    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
        end
        else
        begin
            if (push)
                wr_ptr <= wr_ptr + 1'b1;
            if (pop)
                rd_ptr <= rd_ptr + 1'b1;
            count <= count + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule

//--- core/uplink_trigger_sync.sv
/*
 * Uplink trigger, sync and output routing for a W-CDMA UE generator.
 * Assumes rear-panel trigger pins and the external chip clock arrive
 * asynchronously; the baseband stream arrives on core_clk.
 */
`timescale 1ns/10ps

// Functional notes
// - Frame trigger acts as SFN reset pulse or frame clock, per sfn_source.
// - Sync pulse follows trigger after 1024 chips plus timing and slot offsets.
// - SFN reset source adds another 10 ms of delay.
// - Trigger-to-sync delay path runs only in DPCH mode.
// - Output stream leaves a fixed latency after the sync pulse.
// - Frame trigger sets frame timing so the frame count follows the base station.
// - DPCH: second trigger ends compressed mode at the stop frame number.
// - Stop triggers are ignored unless compressed mode is enabled.
// - DPCH with compressed mode and TPC off: gate trigger starts the pattern.
// - TPC enabled: gate trigger steps DPCH power up or down.
// - DPCH: gate trigger acts only with compressed mode or TPC enabled.
// - DPCH: power control pulse inserts next user TPC bits.
// - External source selected: chip clock comes from the external clock input.
// - External chip clock is multiplied by one, two or four.
// - DPCH events default to DPDCH data, DPDCH clock, none, none.
// - DPCH aux defaults: DPCCH data, chip clock, sync reply.
// - PRACH: second trigger starts message part when AICH triggering is set.
// - PRACH: gate trigger starts the PRACH pattern when PRACH is selected.
// - Frame clock periods of 10, 20, 40, 80 or 2560 ms are accepted.
// - Frame trigger, rear outputs and stream align to the chip clock leading edge; gate, second and power triggers do not.
// - PRACH outputs all default to none.
module uplink_trigger_sync (
    // Clock and reset
    input wire logic core_clk,
    input wire logic nrst,
    // Rear-panel trigger pins
    input wire logic frame_trigger_input,
    input wire logic second_trigger_input,
    input wire logic gate_trigger_input,
    input wire logic power_control_input,
    input wire logic external_chip_clock_input,
    // Configuration
    input wire uplink_trigger_sync_pkg::cfg_t cfg,
    input wire logic map_write,
    input wire uplink_trigger_sync_pkg::out_map_t map_value,
    input wire logic tpc_up_down,
    // Internal signal sources
    input wire logic dpdch_data,
    input wire logic dpcch_data,
    input wire logic msg_data,
    input wire logic preamble_pulse,
    // Baseband stream in
    input wire logic bb_valid,
    output logic bb_ready,
    input wire logic [7:0] bb_data,
    // Generated stream out
    output logic tx_valid,
    output logic [7:0] tx_data,
    // Events and status
    output uplink_trigger_sync_pkg::evt_t events,
    output logic cm_active,
    output logic [11:0] cfn,
    output logic tpc_power_up,
    output logic [6:0] rear_out,
    output uplink_trigger_sync_pkg::out_map_t out_map
);
    ////////////////////////////////////////////////////////////////////////
    logic [1:0] frm_s, sec_s, gate_s, pwr_s, ext_s;
    logic frm_d, sec_d, gate_d, pwr_d, ext_d;
    logic frm_rise, sec_rise, gate_rise, pwr_rise, ext_rise;
    logic chip_en;
    logic [7:0] int_div;
    logic [1:0] mult_cnt;
    logic [7:0] ext_period, ext_since;
    logic [7:0] sub_cnt;
    logic pend_trig;
    logic delay_run;
    logic [23:0] delay_cnt;
    logic [23:0] delay_target;
    logic sync_now;
    logic lat_run;
    logic [7:0] lat_cnt;
    logic release_now;
    logic [1:0] chip_half;
    logic chip_clk_level;
    logic bit_clk;
    logic sync_hold;
    uplink_trigger_sync_pkg::mode_t mode_q;
    logic fifo_valid, fifo_ready;
    logic [7:0] fifo_data;
    logic tx_gate;
    logic [6:0] next_rear;

    function automatic logic rise(input logic now, input logic prev);
        return now && !prev;
    endfunction

    // Two-flop synchronisers; only the second stage feeds logic
    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            frm_s <= '0; sec_s <= '0; gate_s <= '0; pwr_s <= '0; ext_s <= '0;
            frm_d <= 1'b0; sec_d <= 1'b0; gate_d <= 1'b0; pwr_d <= 1'b0; ext_d <= 1'b0;
        end
        else
        begin
            frm_s <= {frm_s[0], frame_trigger_input};
            sec_s <= {sec_s[0], second_trigger_input};
            gate_s <= {gate_s[0], gate_trigger_input};
            pwr_s <= {pwr_s[0], power_control_input};
            ext_s <= {ext_s[0], external_chip_clock_input};
            frm_d <= frm_s[1]; sec_d <= sec_s[1]; gate_d <= gate_s[1];
            pwr_d <= pwr_s[1]; ext_d <= ext_s[1];
        end
    end

    assign frm_rise = rise(frm_s[1], frm_d);
    assign sec_rise = rise(sec_s[1], sec_d);
    assign gate_rise = rise(gate_s[1], gate_d);
    assign pwr_rise = rise(pwr_s[1], pwr_d);
    assign ext_rise = rise(ext_s[1], ext_d);

    ////////////////////////////////////////////////////////////////////////
    // Chip enable. External edges are subdivided using the last measured period,
    // so multiplied rates track only after one reference period.
    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            int_div <= 8'h00;
            ext_period <= 8'hff;
            ext_since <= 8'h00;
            sub_cnt <= 8'h00;
            mult_cnt <= 2'h0;
            chip_en <= 1'b0;
        end
        else
        begin
            int_div <= (int_div == uplink_trigger_sync_pkg::INT_CHIP_DIV_W - 8'h01) ? 8'h00 : int_div + 8'h01;
            ext_since <= ext_rise ? 8'h00 : ((ext_since == 8'hff) ? ext_since : ext_since + 8'h01);
            if (ext_rise)
                ext_period <= ext_since;
            if (!cfg.ext_clk_source)
                chip_en <= (int_div == 8'h00);
            else if (ext_rise)
            begin
                chip_en <= 1'b1;
                sub_cnt <= 8'h00;
                mult_cnt <= 2'h0;
            end
            else if (cfg.ext_mult != uplink_trigger_sync_pkg::MULT_X1 &&
                     sub_cnt == (ext_period >> ((cfg.ext_mult == uplink_trigger_sync_pkg::MULT_X4) ? 2 : 1)) &&
                     mult_cnt != ((cfg.ext_mult == uplink_trigger_sync_pkg::MULT_X4) ? 2'h3 : 2'h1))
            begin
                chip_en <= 1'b1;
                sub_cnt <= 8'h00;
                mult_cnt <= mult_cnt + 2'h1;
            end
            else
            begin
                chip_en <= 1'b0;
                sub_cnt <= sub_cnt + 8'h01;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // base plus offsets; SFN adds 10 ms
    assign delay_target = uplink_trigger_sync_pkg::DELAY_BASE + {12'h000, cfg.timing_offset}
                          + {12'h000, cfg.slot_offset}
                          + (cfg.sfn_source ? uplink_trigger_sync_pkg::DELAY_SFN : 24'h000000);
    assign sync_now = delay_run && chip_en && (delay_cnt >= delay_target);
    assign release_now = lat_run && chip_en && (lat_cnt == uplink_trigger_sync_pkg::PROC_LATENCY_CHIPS);

    // Trigger catch: the pin edge is held until the next chip edge
    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
            pend_trig <= 1'b0;
        else if (frm_rise)
            pend_trig <= 1'b1;
        else if (chip_en)
            pend_trig <= 1'b0;
    end

    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            delay_run <= 1'b0;
            delay_cnt <= 24'h000000;
        end
        // pulse or frame clock; any frame clock period restarts timing
        else if (pend_trig && chip_en && cfg.mode == uplink_trigger_sync_pkg::MODE_DPCH)
        begin
            delay_run <= 1'b1;
            delay_cnt <= 24'h000001;
        end
        else if (sync_now || cfg.mode != uplink_trigger_sync_pkg::MODE_DPCH)
            delay_run <= 1'b0;
        else if (delay_run && chip_en)
            delay_cnt <= delay_cnt + 24'h000001;
    end

    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            lat_run <= 1'b0;
            lat_cnt <= 8'h00;
            tx_gate <= 1'b0;
        end
        else if (sync_now)
        begin
            lat_run <= 1'b1;
            lat_cnt <= 8'h00;
        end
        else if (release_now)
        begin
            lat_run <= 1'b0;
            tx_gate <= 1'b1;
        end
        else if (lat_run && chip_en)
            lat_cnt <= lat_cnt + 8'h01;
    end

    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
            cfn <= uplink_trigger_sync_pkg::CFN_RESET;
        else if (sync_now)
            cfn <= uplink_trigger_sync_pkg::CFN_RESET;
        else if (pend_trig && chip_en && !cfg.sfn_source)
            cfn <= cfn + 12'h001;
    end

    ////////////////////////////////////////////////////////////////////////
    // Trigger decode, one pulse per event
    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            events <= '0;
            cm_active <= 1'b0;
            tpc_power_up <= 1'b0;
        end
        else
        begin
            events <= '0;
            events.sync_pulse <= sync_now;
            if (cfg.mode == uplink_trigger_sync_pkg::MODE_DPCH)
            begin
                // gate gated by CM or TPC
                if (gate_rise && cfg.tpc_enable)
                begin
                    events.tpc_step <= 1'b1;
                    tpc_power_up <= tpc_up_down;
                end
                else if (gate_rise && cfg.cm_enable)
                begin
                    events.cm_start <= 1'b1;
                    cm_active <= 1'b1;
                end
                // stop at stop frame; only with CM enabled
                if (sec_rise && cfg.cm_enable)
                    events.cm_stop <= 1'b1;
                if (cm_active && cfg.cm_enable && cfn == cfg.stop_frame_number_field && sec_rise && !(gate_rise && !cfg.tpc_enable))
                    cm_active <= 1'b0;
                if (!cfg.cm_enable)
                    cm_active <= 1'b0;
                events.tpc_bits <= pwr_rise;
            end
            else
            begin
                events.prach_start <= gate_rise && cfg.prach_selected;
                events.msg_start <= sec_rise && cfg.msg_aich;
                cm_active <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Output routing
    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            mode_q <= uplink_trigger_sync_pkg::MODE_DPCH;
            out_map <= uplink_trigger_sync_pkg::default_map(uplink_trigger_sync_pkg::MODE_DPCH);
        end
        else
        begin
            mode_q <= cfg.mode;
            if (cfg.mode != mode_q)
                out_map <= uplink_trigger_sync_pkg::default_map(cfg.mode);
            else if (map_write)
                out_map <= map_value;
        end
    end

    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            chip_half <= 2'h0;
            chip_clk_level <= 1'b0;
            bit_clk <= 1'b0;
            sync_hold <= 1'b0;
        end
        else
        begin
            if (chip_en)
            begin
                chip_clk_level <= 1'b1;
                chip_half <= chip_half + 2'h1;
                bit_clk <= ~bit_clk;
            end
            else
                chip_clk_level <= 1'b0;
            sync_hold <= sync_now;
        end
    end

    always_comb
    begin
        for (int i = 0; i < 7; i++)
        begin
            unique case (out_map.sel[i])
                uplink_trigger_sync_pkg::SEL_NONE: next_rear[i] = 1'b0;
                uplink_trigger_sync_pkg::SEL_DPDCH_DATA: next_rear[i] = dpdch_data;
                uplink_trigger_sync_pkg::SEL_DPDCH_CLK: next_rear[i] = bit_clk;
                uplink_trigger_sync_pkg::SEL_DPCCH_DATA: next_rear[i] = dpcch_data;
                uplink_trigger_sync_pkg::SEL_CHIP_CLK: next_rear[i] = chip_clk_level;
                uplink_trigger_sync_pkg::SEL_SYNC_REPLY: next_rear[i] = sync_hold;
                uplink_trigger_sync_pkg::SEL_MSG_DATA: next_rear[i] = msg_data;
                uplink_trigger_sync_pkg::SEL_MSG_CLK: next_rear[i] = bit_clk;
                uplink_trigger_sync_pkg::SEL_PREAMBLE: next_rear[i] = preamble_pulse;
                uplink_trigger_sync_pkg::SEL_FRAME_SYNC: next_rear[i] = pend_trig;
                default: next_rear[i] = 1'b0;
            endcase
        end
    end

    // outputs change on chip edges only
    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
            rear_out <= '0;
        else if (chip_en)
            rear_out <= next_rear;
    end

    ////////////////////////////////////////////////////////////////////////
    // Stream: held in the FIFO until the latency window opens, one word a chip
    sample_fifo #(
        .W(uplink_trigger_sync_pkg::FIFO_W),
        .D(uplink_trigger_sync_pkg::FIFO_D)
    ) u_fifo (
        .core_clk(core_clk),
        .nrst(nrst),
        .in_valid(bb_valid),
        .in_ready(fifo_ready),
        .in_data(bb_data),
        .out_valid(fifo_valid),
        .out_ready(tx_gate && chip_en),
        .out_data(fifo_data)
    );

    assign bb_ready = fifo_ready;

    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            tx_valid <= 1'b0;
            tx_data <= 8'h00;
        end
        else
        begin
            tx_valid <= tx_gate && chip_en && fifo_valid;
            if (tx_gate && chip_en && fifo_valid)
                tx_data <= fifo_data;
        end
    end
endmodule

//--- verif/uplink_trigger_sync_properties.sv
/* Checker for the trigger and sync block.
   Assumes it is bound to the top module and sees only its ports. */
`timescale 1ns/10ps
module uplink_trigger_sync_properties (
    // Clock and reset
    input wire logic core_clk,
    input wire logic nrst,
    // Watched ports
    input wire uplink_trigger_sync_pkg::cfg_t cfg,
    input wire uplink_trigger_sync_pkg::evt_t events,
    input wire logic cm_active,
    input wire logic [11:0] cfn,
    input wire logic tx_valid,
    input wire uplink_trigger_sync_pkg::out_map_t out_map
);
    localparam uplink_trigger_sync_pkg::out_map_t DPCH_MAP = 28'h5430021;
    wire dpch = cfg.mode == uplink_trigger_sync_pkg::MODE_DPCH;
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!nrst);
    ////////////////////////////////////////
    property p_dpch_map;
        $changed(cfg.mode) && dpch |-> ##[1:4] out_map == DPCH_MAP;
    endproperty
    a_dpch_map: assert property (p_dpch_map)
        else $error("dpch defaults not reloaded");
    property p_prach_map;
        $changed(cfg.mode) && !dpch |-> ##[1:4] out_map == '0;
    endproperty
    a_prach_map: assert property (p_prach_map)
        else $error("prach defaults not reloaded");
    property p_sync_dpch;
        events.sync_pulse |-> dpch ##1 !events.sync_pulse;
    endproperty
    a_sync_dpch: assert property (p_sync_dpch)
        else $error("sync pulse outside dpch or too long");
    property p_cm_start;
        events.cm_start |-> dpch && cfg.cm_enable && !cfg.tpc_enable;
    endproperty
    a_cm_start: assert property (p_cm_start)
        else $error("cm start without cm enable");
    property p_cm_stop;
        events.cm_stop |-> dpch && cfg.cm_enable;
    endproperty
    a_cm_stop: assert property (p_cm_stop)
        else $error("cm stop without cm enable");
    property p_cm_fall;
        $fell(cm_active) |-> $past(cfn) == $past(cfg.stop_frame_number_field);
    endproperty
    a_cm_fall: assert property (p_cm_fall)
        else $error("cm ended away from stop frame");
    property p_tpc_step;
        events.tpc_step |-> dpch && cfg.tpc_enable;
    endproperty
    a_tpc_step: assert property (p_tpc_step)
        else $error("tpc step without tpc enable");
    property p_tpc_bits;
        events.tpc_bits |-> dpch;
    endproperty
    a_tpc_bits: assert property (p_tpc_bits)
        else $error("tpc bits in prach");
    property p_prach;
        events.prach_start |-> !dpch && cfg.prach_selected;
    endproperty
    a_prach: assert property (p_prach)
        else $error("prach start not allowed");
    property p_msg;
        events.msg_start |-> !dpch && cfg.msg_aich;
    endproperty
    a_msg: assert property (p_msg)
        else $error("message start not allowed");
    property p_tx;
        tx_valid |=> !tx_valid;
    endproperty
    a_tx: assert property (p_tx)
        else $error("tx word held past one cycle");
endmodule

//--- verif/trigger_source_model.sv
/* Test equipment model: trigger pulses and external chip clock.
   Assumes one-cycle request strobes on core_clk. */
`timescale 1ns/10ps
module trigger_source_model #(
    parameter int PW = 4,
    parameter int HALF = 32
) (
    // Clock
    input wire logic core_clk,
    // Requests
    input wire logic [3:0] fire,
    input wire logic ext_run,
    // Pins
    output logic [3:0] pins,
    output logic ext_clk
);
    int cnt [4] = '{0, 0, 0, 0};
    int e = 0;
    initial {pins, ext_clk} = 5'h00;
    ////////////////////////////////////////
    // clean single pulse
    always @(posedge core_clk)
    begin
        for (int i = 0; i < 4; i++)
        begin
            cnt[i] <= fire[i] ? PW : (cnt[i] > 0 ? cnt[i] - 1 : 0);
            pins[i] <= fire[i] || cnt[i] > 1;
        end
    end
    // Clock stands still while not running
    always @(posedge core_clk)
    begin
        e <= (!ext_run || e == HALF - 1) ? 0 : e + 1;
        if (ext_run && e == HALF - 1)
            ext_clk <= !ext_clk;
    end
endmodule

//--- verif/uplink_trigger_sync_tb_top.sv
/* Bench top for the trigger and sync block.
   Assumes the model and checker are compiled first. */
`timescale 1ns/10ps
`define CHK(n, e, s) \
    begin \
        check_count++; \
        if ((s) !== (e)) \
        begin \
            n_errors++; \
            $display("mismatch %s exp %0h got %0h", n, e, s); \
        end \
    end
module uplink_trigger_sync_tb_top;
    logic core_clk, nrst, ext_run, ext_clk, map_write, tpc_up_down;
    logic bb_valid, bb_ready, tx_valid, cm_active, tpc_power_up;
    logic [3:0] fire, pins;
    logic [7:0] bb_data, tx_data, watch;
    logic [11:0] cfn;
    logic [6:0] rear_out;
    uplink_trigger_sync_pkg::cfg_t cfg;
    uplink_trigger_sync_pkg::out_map_t map_value, out_map;
    uplink_trigger_sync_pkg::evt_t events;
    int n_errors = 0;
    int check_count = 0;
    localparam uplink_trigger_sync_pkg::out_map_t DPCH_MAP = 28'h5430021;
    assign watch = {tx_valid, events};
    trigger_source_model model (.core_clk(core_clk), .fire(fire), .ext_run(ext_run),
        .pins(pins), .ext_clk(ext_clk));
    uplink_trigger_sync dut (.core_clk(core_clk), .nrst(nrst), .frame_trigger_input(pins[0]),
        .second_trigger_input(pins[1]), .gate_trigger_input(pins[2]), .power_control_input(pins[3]),
        .external_chip_clock_input(ext_clk), .cfg(cfg), .map_write(map_write), .map_value(map_value),
        .tpc_up_down(tpc_up_down), .dpdch_data(tpc_up_down), .dpcch_data(1'b0), .msg_data(1'b0),
        .preamble_pulse(1'b0), .bb_valid(bb_valid), .bb_ready(bb_ready), .bb_data(bb_data),
        .tx_valid(tx_valid), .tx_data(tx_data), .events(events), .cm_active(cm_active), .cfn(cfn),
        .tpc_power_up(tpc_power_up), .rear_out(rear_out), .out_map(out_map));
    ////////////////////////////////////////
    task automatic finish_test();
        $display("checks %0d mismatches %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task automatic pulse(input int pin);
        @(posedge core_clk);
        fire <= 4'h1 << pin;
        @(posedge core_clk);
        fire <= 4'h0;
    endtask
    task automatic wait_hi(input int b, input int lim, output int t);
        t = 0;
        while (watch[b] !== 1'b1 && t < lim)
        begin
            @(posedge core_clk);
            t++;
        end
        if (watch[b] !== 1'b1)
        begin
            n_errors++;
            $display("mismatch wait %0d exp 1 got 0", b);
            finish_test();
        end
    endtask
    task automatic expect_evt(input int pin, input int b, input logic exp, input string nm);
        logic seen = 1'b0;
        pulse(pin);
        repeat (80)
        begin
            @(posedge core_clk);
            seen = seen | events[b];
        end
        `CHK(nm, exp, seen)
    endtask
    ////////////////////////////////////////
    task automatic t_map();
        `CHK("reset map", DPCH_MAP, out_map)
        `CHK("reset ready", 1'b1, bb_ready)
        cfg.mode <= uplink_trigger_sync_pkg::MODE_PRACH;
        repeat (6) @(posedge core_clk);
        `CHK("prach map", 28'h0, out_map)
        map_write <= 1'b1;
        map_value <= 28'h1234567;
        @(posedge core_clk);
        map_write <= 1'b0;
        repeat (3) @(posedge core_clk);
        `CHK("user map", 28'h1234567, out_map)
        cfg.mode <= uplink_trigger_sync_pkg::MODE_DPCH;
        repeat (6) @(posedge core_clk);
        `CHK("reload map", DPCH_MAP, out_map)
        $display("test map done");
    endtask
    task automatic t_dpch();
        expect_evt(2, 5, 1'b0, "gate idle");
        cfg.cm_enable <= 1'b1;
        expect_evt(2, 5, 1'b1, "cm start");
        `CHK("cm on", 1'b1, cm_active)
        expect_evt(1, 4, 1'b1, "cm stop");
        `CHK("cm off", 1'b0, cm_active)
        cfg.cm_enable <= 1'b0;
        cfg.tpc_enable <= 1'b1;
        expect_evt(1, 4, 1'b0, "stop idle");
        tpc_up_down <= 1'b1;
        expect_evt(2, 3, 1'b1, "tpc up");
        `CHK("power up", 1'b1, tpc_power_up)
        `CHK("e1 up", 1'b1, rear_out[0])
        tpc_up_down <= 1'b0;
        expect_evt(2, 3, 1'b1, "tpc down");
        `CHK("power down", 1'b0, tpc_power_up)
        `CHK("e1 down", 1'b0, rear_out[0])
        expect_evt(3, 2, 1'b1, "tpc bits");
        $display("test dpch done");
    endtask
    task automatic t_prach();
        cfg.mode <= uplink_trigger_sync_pkg::MODE_PRACH;
        cfg.msg_aich <= 1'b1;
        expect_evt(2, 1, 1'b0, "prach idle");
        cfg.prach_selected <= 1'b1;
        expect_evt(2, 1, 1'b1, "prach start");
        expect_evt(1, 0, 1'b1, "msg start");
        expect_evt(3, 2, 1'b0, "power idle");
        cfg.mode <= uplink_trigger_sync_pkg::MODE_DPCH;
        repeat (6) @(posedge core_clk);
        $display("test prach done");
    endtask
    task automatic t_fifo();
        int n = 0;
        bb_valid <= 1'b1;
        bb_data <= 8'h00;
        repeat (40)
        begin
            @(posedge core_clk);
            n += bb_ready;
            bb_data <= n[7:0];
        end
        bb_valid <= 1'b0;
        `CHK("fifo fill", 16, n)
        $display("test fifo done");
    endtask
    task automatic t_sync();
        int t;
        pulse(0);
        wait_hi(6, 70000, t);
        `CHK("sync delay", 1'b1, t > 66550 && t < 66660)
        @(posedge core_clk);
        `CHK("cfn at sync", 12'h000, cfn)
        for (int k = 0; k < 16; k++)
        begin
            wait_hi(7, 1200, t);
            if (k == 0)
                `CHK("tx latency", 1'b1, t > 1160 && t < 1180)
            `CHK("tx word", k[7:0], tx_data)
            @(posedge core_clk);
        end
        `CHK("fifo drained", 1'b1, bb_ready)
        repeat (2)
        begin
            pulse(0);
            repeat (80) @(posedge core_clk);
        end
        `CHK("cfn count", 12'h002, cfn)
        $display("test sync done");
    endtask
    task automatic t_ext();
        int t;
        ext_run <= 1'b1;
        cfg.ext_clk_source <= 1'b1;
        cfg.ext_mult <= uplink_trigger_sync_pkg::MULT_X4;
        repeat (400) @(posedge core_clk);
        pulse(0);
        wait_hi(6, 20000, t);
        `CHK("ext delay", 1'b1, t > 15000 && t < 17800)
        $display("test ext done");
    endtask
    ////////////////////////////////////////
    initial
    begin
        core_clk = 1'b0;
        forever #2 core_clk = !core_clk;
    end
    initial
    begin
        {nrst, ext_run, map_write, tpc_up_down, bb_valid} = 5'h00;
        {fire, bb_data, cfg, map_value} = '0;
        repeat (8) @(posedge core_clk);
        nrst <= 1'b1;
        @(posedge core_clk);
        t_map();
        t_dpch();
        t_prach();
        t_fifo();
        t_sync();
        t_ext();
        finish_test();
    end
endmodule
bind uplink_trigger_sync uplink_trigger_sync_properties chk (.core_clk(core_clk), .nrst(nrst), .cfg(cfg),
    .events(events), .cm_active(cm_active), .cfn(cfn), .tx_valid(tx_valid), .out_map(out_map));
